/* File: inc/pav_pkg.sv */
// Package with register map, field positions, codes and carriers for the management register bank.
// Operation
// - Parallel detection fault latches high in expansion register; management cannot write it.
// - Expansion bit reports whether the link partner offers a next page.
// - Local next page capable bit always reads zero.
// - Page received latches high on a new page; a read of expansion clears it.
// - Expansion bit shows link partner negotiation capability; resets to zero.
// - Reserved expansion bits read zero and writes to them are ignored.
// - Force 100 link bit reports good 100 Mbit/s link regardless of line.
// - Writing one to state machine reset resets PHY machines; bit self-clears when done.
// - Read/write preamble suppression control bit, reset value zero.
// - Writing one to sleep powers down all but oscillator and clock generator.
// - Clearing sleep keeps configuration and resets the PHY state machines.
// - Remote loop out routes received line data back to the transmit channel.
// - Negotiation completion loads four read-only result bits; all reset to one.
// - Five-bit read/write PHY address resets to 00001; sent MSB first on link.
// - PHY address 00000 sets the isolate bit of the basic control register.
// - Four-bit read-only monitor field shows negotiation progress codes 0000 to 1000.
package pav_pkg;

    // Register addresses on the management link.
    localparam logic [4:0] PAV_ADDR_EXPANSION   = 5'h06;
    localparam logic [4:0] PAV_ADDR_CONFIG      = 5'h10;
    localparam logic [4:0] PAV_ADDR_CONFIG_STAT = 5'h11;

    // Expansion register field positions.
    localparam int PAV_EXP_PDF     = 4;
    localparam int PAV_EXP_LP_NP   = 3;
    localparam int PAV_EXP_NP      = 2;
    localparam int PAV_EXP_PAGE_RX = 1;
    localparam int PAV_EXP_LP_AN   = 0;

    // Configuration register field positions.
    localparam int PAV_CFG_FORCE100 = 7;
    localparam int PAV_CFG_STATE_MACHINE_RESET    = 3;
    localparam int PAV_CFG_PREAMBLE = 2;
    localparam int PAV_CFG_SLEEP    = 1;
    localparam int PAV_CFG_LOOPOUT  = 0;

    // Configuration and status register field positions.
    localparam int PAV_CS_RESULT_LSB = 12;
    localparam int PAV_CS_RSVD_LSB   = 9;
    localparam int PAV_CS_ADDR_LSB   = 4;
    localparam int PAV_CS_MON_LSB    = 0;

    // Reset values.
    localparam logic [3:0] PAV_RESULT_RESET = 4'hf;
    localparam logic [4:0] PAV_ADDR_RESET   = 5'h01;
    localparam logic [4:0] PAV_ADDR_ISOLATE = 5'h00;
    localparam logic       PAV_LOCAL_NP     = 1'b0;

    // Length of the state machine reset pulse.
    localparam int         PAV_CLK_PERIOD_NS = 100;
    localparam int         PAV_STATE_MACHINE_RESET_TIME_NS = 1000;
    localparam int         PAV_STATE_MACHINE_RESET_CYC_INT =
        (PAV_STATE_MACHINE_RESET_TIME_NS + PAV_CLK_PERIOD_NS - 1) / PAV_CLK_PERIOD_NS;
    localparam logic [3:0] PAV_STATE_MACHINE_RESET_CYCLES  = 4'(PAV_STATE_MACHINE_RESET_CYC_INT);

    // Negotiation monitor codes.
    typedef enum logic [3:0] {
        PAV_MON_IDLE        = 4'h0,
        PAV_MON_ABILITY     = 4'h1,
        PAV_MON_ACK         = 4'h2,
        PAV_MON_ACK_FAIL    = 4'h3,
        PAV_MON_CONSIST     = 4'h4,
        PAV_MON_CONSIST_BAD = 4'h5,
        PAV_MON_PD_READY    = 4'h6,
        PAV_MON_PD_FAIL     = 4'h7,
        PAV_MON_COMPLETE    = 4'h8
    } pav_mon_t;

    // Management access request.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } pav_mgmt_req_t;

    // Events and levels from the negotiation engine.
    typedef struct packed {
        logic       pd_fault;
        logic       page_rx;
        logic       partner_np;
        logic       partner_an;
        logic       an_done;
        logic [3:0] an_result;
        pav_mon_t   monitor;
    } pav_an_stat_t;

    // Controls that steer the PHY.
    typedef struct packed {
        logic       link_good_100;
        logic       sm_reset;
        logic       preamble_suppress;
        logic       sleep;
        logic       remote_loop_out;
        logic       isolate;
        logic [4:0] station_address;
    } pav_ctrl_t;

endpackage : pav_pkg

/* File: design/pav_reset_seq.sv */
// Sequencer that stretches a reset request into a fixed-length state machine reset.
`timescale 1ns/10ps
module pav_reset_seq (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Request and status.
    input  wire logic start,
    output logic      busy
);
    import pav_pkg::*;

    logic [3:0] count_q;

    // Loads the length on a request and counts down to zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 4'h0;
        end else if (start) begin
            count_q <= PAV_STATE_MACHINE_RESET_CYCLES;
        end else if (count_q != 4'h0) begin
            count_q <= count_q - 4'h1;
        end
    end

    // Busy while the count runs.
    assign busy = (count_q != 4'h0);

endmodule : pav_reset_seq

/* File: design/pav_regs.sv */
// Management register bank for expansion, vendor configuration and vendor status registers.
`timescale 1ns/10ps
module pav_regs (
    // Clock and reset.
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // Management access.
    input  wire pav_pkg::pav_mgmt_req_t mgmt_req,
    output logic [15:0]                 mgmt_rdata,
    output logic                        mgmt_rvalid,
    // Negotiation engine status.
    input  wire pav_pkg::pav_an_stat_t  an_stat,
    input  wire logic                   line_link_100,
    // PHY controls.
    output pav_pkg::pav_ctrl_t          phy_ctrl
);
    import pav_pkg::*;

    // Expansion register state.
    logic       pd_fault_q;
    logic       page_rx_q;
    logic       partner_np_q;
    logic       partner_an_q;

    // Configuration register state.
    logic       force100_q;
    logic       state_machine_reset_req;
    logic       preamble_q;
    logic       sleep_q;
    logic       loopout_q;

    // Configuration and status register state.
    logic [3:0] result_q;
    logic [2:0] cs_rsvd_q;
    logic [4:0] address_q;
    logic [3:0] monitor_q;

    // Read data path.
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic        rvalid_q;

    // Decoded accesses.
    logic wr_cfg;
    logic wr_cs;
    logic rd_exp;
    logic wake;
    logic seq_busy;

    // Address decode of the management strobes.
    assign wr_cfg = mgmt_req.wr && (mgmt_req.addr == PAV_ADDR_CONFIG);
    assign wr_cs  = mgmt_req.wr && (mgmt_req.addr == PAV_ADDR_CONFIG_STAT);
    assign rd_exp = mgmt_req.rd && (mgmt_req.addr == PAV_ADDR_EXPANSION);

    // Leaving sleep is a write that clears a set sleep bit.
    assign wake = wr_cfg && sleep_q && !mgmt_req.wdata[PAV_CFG_SLEEP];

    // Reset request from a written one or from waking up.
    assign state_machine_reset_req = (wr_cfg && mgmt_req.wdata[PAV_CFG_STATE_MACHINE_RESET]) || wake;

    // Sequencer that times the state machine reset.
    pav_reset_seq u_reset_seq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .start   (state_machine_reset_req),
        .busy    (seq_busy)
    );

    // Parallel detection fault latches high; a read clears it, a new fault wins.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_fault_q <= 1'b0;
        end else if (an_stat.pd_fault) begin
            pd_fault_q <= 1'b1;
        end else if (rd_exp) begin
            pd_fault_q <= 1'b0;
        end
    end

    // Page received latches high; a read of the expansion register clears it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_rx_q <= 1'b0;
        end else if (an_stat.page_rx) begin
            page_rx_q <= 1'b1;
        end else if (rd_exp) begin
            page_rx_q <= 1'b0;
        end
    end

    // Link partner capability levels follow the negotiation engine.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_np_q <= 1'b0;
            partner_an_q <= 1'b0;
        end else begin
            partner_np_q <= an_stat.partner_np;
            partner_an_q <= an_stat.partner_an;
        end
    end

    // Writable configuration bits; they survive sleep untouched.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            force100_q <= 1'b0;
            preamble_q <= 1'b0;
            loopout_q  <= 1'b0;
        end else if (wr_cfg) begin
            force100_q <= mgmt_req.wdata[PAV_CFG_FORCE100];
            preamble_q <= mgmt_req.wdata[PAV_CFG_PREAMBLE];
            loopout_q  <= mgmt_req.wdata[PAV_CFG_LOOPOUT];
        end
    end

    // Sleep bit, set and cleared by management.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_q <= 1'b0;
        end else if (wr_cfg) begin
            sleep_q <= mgmt_req.wdata[PAV_CFG_SLEEP];
        end
    end

    // Negotiated mode loads on completion and otherwise holds.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= PAV_RESULT_RESET;
        end else if (an_stat.an_done) begin
            result_q <= an_stat.an_result;
        end
    end

    // Station address and the reserved storage of the status register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            address_q <= PAV_ADDR_RESET;
            cs_rsvd_q <= 3'h0;
        end else if (wr_cs) begin
            address_q <= mgmt_req.wdata[PAV_CS_ADDR_LSB +: 5];
            cs_rsvd_q <= mgmt_req.wdata[PAV_CS_RSVD_LSB +: 3];
        end
    end

    // Monitor code tracks the negotiation engine progress.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_q <= PAV_MON_IDLE;
        end else begin
            case (an_stat.monitor)
                PAV_MON_IDLE,
                PAV_MON_ABILITY:     monitor_q <= an_stat.monitor;
                PAV_MON_ACK,
                PAV_MON_ACK_FAIL,
                PAV_MON_CONSIST,
                PAV_MON_CONSIST_BAD,
                PAV_MON_PD_READY,
                PAV_MON_PD_FAIL,
                PAV_MON_COMPLETE:    monitor_q <= an_stat.monitor;
                default:             monitor_q <= monitor_q;
            endcase
        end
    end

    // Read multiplexer; unused expansion and configuration bits and unmapped addresses read zero; status reserved bits read back their stored value.
    always_comb begin
        rdata_d = 16'h0000;
        case (mgmt_req.addr)
            PAV_ADDR_EXPANSION: begin
                rdata_d[PAV_EXP_PDF]     = pd_fault_q;
                rdata_d[PAV_EXP_LP_NP]   = partner_np_q;
                rdata_d[PAV_EXP_NP]      = PAV_LOCAL_NP;
                rdata_d[PAV_EXP_PAGE_RX] = page_rx_q;
                rdata_d[PAV_EXP_LP_AN]   = partner_an_q;
            end
            PAV_ADDR_CONFIG: begin
                rdata_d[PAV_CFG_FORCE100] = force100_q;
                rdata_d[PAV_CFG_STATE_MACHINE_RESET]    = seq_busy;
                rdata_d[PAV_CFG_PREAMBLE] = preamble_q;
                rdata_d[PAV_CFG_SLEEP]    = sleep_q;
                rdata_d[PAV_CFG_LOOPOUT]  = loopout_q;
            end
            PAV_ADDR_CONFIG_STAT: begin
                rdata_d[PAV_CS_RESULT_LSB +: 4] = result_q;
                rdata_d[PAV_CS_RSVD_LSB +: 3]   = cs_rsvd_q;
                rdata_d[PAV_CS_ADDR_LSB +: 5]   = address_q;
                rdata_d[PAV_CS_MON_LSB +: 4]    = monitor_q;
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    // Read data is captured in the cycle of the read strobe.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= mgmt_req.rd;
            if (mgmt_req.rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign mgmt_rdata  = rdata_q;
    assign mgmt_rvalid = rvalid_q;

    // Controls toward the PHY.
    assign phy_ctrl.link_good_100     = force100_q || line_link_100;
    assign phy_ctrl.sm_reset          = seq_busy;
    assign phy_ctrl.preamble_suppress = preamble_q;
    assign phy_ctrl.sleep             = sleep_q;
    assign phy_ctrl.remote_loop_out   = loopout_q;
    assign phy_ctrl.isolate           = (address_q == PAV_ADDR_ISOLATE);
    assign phy_ctrl.station_address   = address_q;

endmodule : pav_regs

/* File: sim/pav_regs_props.sv */
// Concurrent checks on the ports of the management register bank.
`timescale 1ns/10ps
module pav_regs_props (
    // Clock and reset.
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    // Management access.
    input wire pav_pkg::pav_mgmt_req_t mgmt_req,
    input wire logic [15:0]            mgmt_rdata,
    input wire logic                   mgmt_rvalid,
    // Engine status and controls.
    input wire pav_pkg::pav_an_stat_t  an_stat,
    input wire logic                   line_link_100,
    input wire pav_pkg::pav_ctrl_t     phy_ctrl
);
    import pav_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Decoded strobes per register.
    wire logic rd_exp = mgmt_req.rd && mgmt_req.addr == PAV_ADDR_EXPANSION;
    wire logic rd_cs  = mgmt_req.rd && mgmt_req.addr == PAV_ADDR_CONFIG_STAT;
    wire logic wr_cfg = mgmt_req.wr && mgmt_req.addr == PAV_ADDR_CONFIG;
    wire logic wr_cs  = mgmt_req.wr && mgmt_req.addr == PAV_ADDR_CONFIG_STAT;
    wire logic pr     = an_stat.page_rx;

    a_read_answer: assert property (mgmt_rvalid == $past(mgmt_req.rd))
        else $error("Read answer not one cycle after the strobe.");
    a_exp_fixed: assert property (
        rd_exp |=> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2])
        else $error("Fixed expansion bits not zero.");
    // A fault pulse, a quiet cycle, then a read must show the latched fault.
    a_fault_seen: assert property (
        an_stat.pd_fault ##1 !rd_exp ##1 rd_exp |=> mgmt_rdata[PAV_EXP_PDF])
        else $error("Fault event not latched.");
    a_page_clear: assert property (
        (rd_exp && !pr) ##1 !pr ##1 (rd_exp && !pr) |=> !mgmt_rdata[1])
        else $error("Page bit not cleared by a read.");
    a_state_machine_reset_start: assert property (
        wr_cfg && (mgmt_req.wdata[3] || (phy_ctrl.sleep && !mgmt_req.wdata[1]))
        |=> phy_ctrl.sm_reset)
        else $error("Machine reset not started.");
    a_state_machine_reset_len: assert property (
        $rose(phy_ctrl.sm_reset) |->
        phy_ctrl.sm_reset[*8] ##1 phy_ctrl.sm_reset[*2] ##1 !phy_ctrl.sm_reset)
        else $error("Machine reset length wrong.");
    a_cfg_write: assert property (
        wr_cfg |=> {phy_ctrl.preamble_suppress, phy_ctrl.sleep, phy_ctrl.remote_loop_out}
        == $past(mgmt_req.wdata[2:0]))
        else $error("Config bits not written.");
    a_addr_write: assert property (
        wr_cs |=> phy_ctrl.station_address == $past(mgmt_req.wdata[8:4]))
        else $error("Station address not written.");
    a_isolate_dec: assert property (
        phy_ctrl.isolate == (phy_ctrl.station_address == PAV_ADDR_ISOLATE))
        else $error("Isolate does not follow address.");
    a_line_link: assert property (line_link_100 |-> phy_ctrl.link_good_100)
        else $error("Real link not reported.");
    // Completion pulse, a quiet cycle, then a read must return the loaded mode.
    a_result_load: assert property (
        an_stat.an_done ##1 !an_stat.an_done ##1 rd_cs
        |=> mgmt_rdata[15:12] == $past(an_stat.an_result, 3))
        else $error("Result bits not loaded.");
    // Main scenarios reached.
    c_exp_read: cover property (rd_exp ##1 mgmt_rvalid);
    c_state_machine_reset: cover property ($rose(phy_ctrl.sm_reset));
    c_isolate: cover property (phy_ctrl.isolate);
endmodule : pav_regs_props

/* File: sim/pav_mgmt_model.sv */
// Station management model that issues register reads and writes.
`timescale 1ns/10ps
module pav_mgmt_model (
    // Clock.
    input wire logic               ref_clk,
    // Management access.
    output pav_pkg::pav_mgmt_req_t req,
    input wire logic [15:0]        rdata,
    input wire logic               rvalid
);
    import pav_pkg::*;
    // Idle request at time zero.
    initial req = '0;
    // One write strobe; released lines show inverted data so stale values cannot match.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    // One read strobe; the answer is taken in the cycle after the strobe.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: req.wdata};
        @(posedge ref_clk);
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~req.wdata};
        #1;
        d = rvalid ? rdata : 16'hdead;
    endtask : rd
endmodule : pav_mgmt_model

/* File: sim/testbench.sv */
// Self-checking bench for the management register bank.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    import pav_pkg::*;
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic [15:0] rexp;
    } pav_row_t;
    logic          ref_clk       = 1'b0;
    logic          rst_n         = 1'b0;
    pav_mgmt_req_t mgmt_req;
    logic [15:0]   mgmt_rdata;
    logic          mgmt_rvalid;
    pav_an_stat_t  an_stat       = '0;
    logic          line_link_100 = 1'b0;
    pav_ctrl_t     phy_ctrl;
    logic [15:0]   d;
    int            failures      = 0;
    int            check_count   = 0;
    int            cycles        = 0;
    // Write then read back; reserved, read-only and unmapped places included.
    pav_row_t      rows [6]      = '{'{5'h10, 16'hfff5, 16'h0085}, '{5'h10, 16'h0000, 16'h0000},
        '{5'h11, 16'h0000, 16'hf000}, '{5'h11, 16'h0e50, 16'hfe50},
        '{5'h06, 16'hffff, 16'h0000}, '{5'h15, 16'h1234, 16'h0000}};

    pav_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .an_stat(an_stat), .line_link_100(line_link_100),
        .phy_ctrl(phy_ctrl));
    pav_mgmt_model u_mgmt (.ref_clk(ref_clk), .req(mgmt_req), .rdata(mgmt_rdata),
        .rvalid(mgmt_rvalid));

    // Clock and hang guard.
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    // Verdict and end of run.
    task automatic stop_test();
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // Main sequence.
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        u_mgmt.rd(PAV_ADDR_CONFIG, d);
        `CHK(d, 16'h0000)
        u_mgmt.rd(PAV_ADDR_CONFIG_STAT, d);
        `CHK(d, 16'hf010)
        u_mgmt.rd(PAV_ADDR_EXPANSION, d);
        `CHK(d, 16'h0000)
        foreach (rows[i]) begin
            u_mgmt.wr(rows[i].addr, rows[i].wdata);
            u_mgmt.rd(rows[i].addr, d);
            `CHK(d, rows[i].rexp)
        end
        // Latched events and partner levels, then clear on read.
        @(posedge ref_clk);
        an_stat <= {4'hf, 1'b0, 4'h0, PAV_MON_IDLE};
        @(posedge ref_clk);
        an_stat <= {4'h3, 1'b0, 4'h0, PAV_MON_IDLE};
        u_mgmt.rd(PAV_ADDR_EXPANSION, d);
        `CHK(d, 16'h001b)
        u_mgmt.rd(PAV_ADDR_EXPANSION, d);
        `CHK(d, 16'h0009)
        // Result load on completion.
        @(posedge ref_clk);
        an_stat.an_result <= 4'h5;
        an_stat.an_done <= 1'b1;
        @(posedge ref_clk);
        an_stat.an_done <= 1'b0;
        u_mgmt.rd(PAV_ADDR_CONFIG_STAT, d);
        `CHK(d[15:12], 4'h5)
        // Every monitor code.
        for (int i = 0; i <= 8; i++) begin
            @(posedge ref_clk);
            an_stat.monitor <= pav_mon_t'(i);
            u_mgmt.rd(PAV_ADDR_CONFIG_STAT, d);
            `CHK(d[3:0], 4'(i))
        end
        // An undefined progress code leaves the last code in place.
        @(posedge ref_clk);
        an_stat.monitor <= pav_mon_t'(4'hf);
        u_mgmt.rd(PAV_ADDR_CONFIG_STAT, d);
        `CHK(d[3:0], 4'h8)
        // Forced and real link.
        u_mgmt.wr(PAV_ADDR_CONFIG, 16'h0080);
        @(negedge ref_clk);
        `CHK(phy_ctrl.link_good_100, 1'b1)
        u_mgmt.wr(PAV_ADDR_CONFIG, 16'h0000);
        @(negedge ref_clk);
        `CHK(phy_ctrl.link_good_100, 1'b0)
        @(posedge ref_clk);
        line_link_100 <= 1'b1;
        @(negedge ref_clk);
        `CHK(phy_ctrl.link_good_100, 1'b1)
        // Self-clearing machine reset.
        u_mgmt.wr(PAV_ADDR_CONFIG, 16'h0008);
        @(negedge ref_clk);
        `CHK(phy_ctrl.sm_reset, 1'b1)
        u_mgmt.rd(PAV_ADDR_CONFIG, d);
        `CHK(d[3], 1'b1)
        repeat (12) @(posedge ref_clk);
        u_mgmt.rd(PAV_ADDR_CONFIG, d);
        `CHK(d, 16'h0000)
        // Sleep, then wake with loop-out and suppression set.
        u_mgmt.wr(PAV_ADDR_CONFIG, 16'h0002);
        @(negedge ref_clk);
        `CHK(phy_ctrl.sleep, 1'b1)
        u_mgmt.wr(PAV_ADDR_CONFIG, 16'h0005);
        @(negedge ref_clk);
        `CHK({phy_ctrl.sm_reset, phy_ctrl.sleep, phy_ctrl.preamble_suppress,
            phy_ctrl.remote_loop_out}, 4'b1011)
        repeat (12) @(posedge ref_clk);
        // Second reset in mid-run.
        rst_n <= 1'b0;
        @(negedge ref_clk);
        `CHK(phy_ctrl.station_address, PAV_ADDR_RESET)
        @(posedge ref_clk);
        rst_n <= 1'b1;
        u_mgmt.rd(PAV_ADDR_CONFIG_STAT, d);
        `CHK(d, 16'hf010)
        stop_test();
    end
endmodule : testbench

bind pav_regs pav_regs_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .an_stat(an_stat),
    .line_link_100(line_link_100), .phy_ctrl(phy_ctrl));
